// File: ctad_defs.svh
// Register offsets, field positions and reset values of the datapath.
`ifndef CTAD_DEFS_SVH
`define CTAD_DEFS_SVH
`define CTAD_OFF_CMD 12'h000
`define CTAD_OFF_IMM 12'h004
`define CTAD_OFF_FLAGS 12'h008
`define CTAD_OFF_STATUS 12'h00c
`define CTAD_OFF_GPR 12'h020
`define CTAD_GPR_MASK 12'hfe3
`define CTAD_FLG_C 0
`define CTAD_FLG_V 1
`define CTAD_FLG_Z 2
`define CTAD_FLG_N 3
`define CTAD_FLG_H 5
`define CTAD_ST_BUSY 0
`define CTAD_ST_ILLEGAL 1
`define CTAD_ST_DIV0 2
`define CTAD_FLAGS_RST 8'h00
`define CTAD_WORD_RST 32'h0000_0000
`define CTAD_SP_IDX 3'h7
`endif

// File: ctad_pkg.sv
// Types of the transfer and arithmetic datapath.
`default_nettype none
package ctad_pkg;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00, SZ_WORD = 2'b01, SZ_LONG = 2'b10
  } ctad_size_type;
  typedef enum logic [4:0] {
    OP_MOVE_REG = 5'b00000, OP_MOVE_IMM = 5'b00001,
    OP_MOVE_LOAD = 5'b00010, OP_MOVE_STORE = 5'b00011,
    OP_POP = 5'b00100, OP_PUSH = 5'b00101,
    OP_ADD = 5'b00110, OP_SUB = 5'b00111,
    OP_ADD_WITH_CARRY = 5'b01000, OP_SUB_WITH_CARRY = 5'b01001,
    OP_INC = 5'b01010, OP_DEC = 5'b01011,
    OP_ADDRESS_ADD_CONST = 5'b01100, OP_ADDRESS_SUB_CONST = 5'b01101,
    OP_DECIMAL_ADJUST_ADD = 5'b01110, OP_DECIMAL_ADJUST_SUB = 5'b01111,
    OP_UNSIGNED_MULTIPLY = 5'b10000, OP_SIGNED_MULTIPLY = 5'b10001,
    OP_UNSIGNED_DIVIDE = 5'b10010, OP_SIGNED_DIVIDE = 5'b10011,
    OP_COMPARE = 5'b10100, OP_NEGATE = 5'b10101,
    OP_ZERO_EXTEND = 5'b10110, OP_SIGN_EXTEND = 5'b10111,
    OP_MOVE_FROM_PERIPH = 5'b11000, OP_MOVE_TO_PERIPH = 5'b11001
  } ctad_op_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_MEM = 2'b10
  } ctad_state_type;
  typedef struct packed {
    logic [13:0] spare;
    logic [1:0] step;
    logic [3:0] rs;
    logic [3:0] rd;
    logic use_imm;
    logic [1:0] size;
    ctad_op_type op;
  } ctad_cmd_type;
  typedef logic [7:0][31:0] ctad_gpr_type;
  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ctad_mem_type;
  typedef struct packed {
    ctad_state_type st;
    ctad_cmd_type cmd;
    logic [31:0] imm;
    ctad_gpr_type gpr;
    logic [7:0] flags;
    logic illegal;
    logic div0;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    ctad_mem_type mem;
  } ctad_regs_type;
endpackage
`default_nettype wire

// File: ctad_datapath.sv
// Transfer and arithmetic datapath with its register file and APB slave.
`default_nettype none
`include "ctad_defs.svh"
// Behaviour
// RL1: Move copies data register to register, register to memory, memory to register, immediate.
// RL2: Peripheral-synchronised byte moves are unsupported and only flagged as illegal.
// RL3: Pop reads at the stack pointer, then increments it, like a post-increment move.
// RL4: Push decrements the stack pointer first, then stores the register there.
// RL5: Add and subtract work on byte, word, longword with register or immediate.
// RL6: Plain subtract refuses an immediate byte operand with a byte destination.
// RL7: Add and subtract with carry are byte only and include the carry flag.
// RL8: Increment and decrement by 1 or 2; bytes by 1 only.
// RL9: Address add and subtract use constants 1, 2 or 4, longword only.
// RL10: Decimal adjust corrects a byte to two packed BCD digits using the flags.
// RL11: Unsigned multiply gives 8x8 to 16 or 16x16 to 32 bits.
// RL12: Signed multiply uses the same widths with two's complement operands.
// RL13: Unsigned divide packs quotient and remainder into the destination register.
// RL14: Signed divide has the same widths with two's complement operands.
// RL15: Compare sets the flags from the difference and writes nothing back.
// RL16: Negate replaces the register with zero minus its value.
// RL17: Zero extension widens 8 to 16 or 16 to 32 bits with zeros.
// RL18: Sign extension widens 8 to 16 or 16 to 32 bits copying the sign.
// RL19: Registers are reached as sixteen bytes, sixteen words or eight longwords.
// RL20: Overflow flag reports overflow, negative the top bit, zero a zero result.
// RL21: Carry reports carry for additions and borrow for subtractions.
// RL22: Word and longword memory accesses force address bit 0 to zero.
// RL23: A zero divisor ends at once, leaves the destination unchanged, flags it.
module ctad_datapath
  import ctad_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output ctad_mem_type mem_out,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack
);
  ctad_regs_type r;
  ctad_regs_type n;
  logic [1:0] sz;
  logic [1:0] dsz;
  logic [4:0] sh;
  logic [31:0] stepv;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] adst;
  logic [31:0] x;
  logic [31:0] y;
  logic [31:0] xs;
  logic [31:0] ys;
  logic [31:0] cs;
  logic [32:0] top;
  logic [28:0] half;
  logic [31:0] sum;
  logic [31:0] res;
  logic [31:0] q;
  logic [31:0] rm;
  logic [31:0] spn;
  logic [7:0] f;
  logic [7:0] dadj;
  logic cin;
  logic sub;
  logic v;
  logic bad;

  // Left shift that puts the sign bit of each size at bit 31.
  function automatic logic [4:0] shift_of(logic [1:0] s);
    case (s)
      SZ_BYTE: shift_of = 5'h18;
      SZ_WORD: shift_of = 5'h10;
      default: shift_of = 5'h00;
    endcase
  endfunction

  function automatic logic [31:0] size_mask(logic [1:0] s, logic [31:0] val);
    size_mask = (val << shift_of(s)) >> shift_of(s);
  endfunction

  function automatic logic [31:0] size_bytes(logic [1:0] s);
    size_bytes = (s == SZ_LONG) ? 32'h0000_0004 : 32'h0000_0002;
  endfunction

  function automatic logic [31:0] even_addr(logic [1:0] s, logic [31:0] ad);
    even_addr = (s == SZ_BYTE) ? ad : {ad[31:1], 1'b0}; // [RL22]
  endfunction

  // Byte index 0-7 selects bits 15:8, 8-15 bits 7:0; word 8-15 the upper half.
  function automatic logic [31:0] rd_op(ctad_gpr_type g, logic [1:0] s, logic [3:0] i);
    case (s)
      SZ_BYTE: rd_op = i[3] ? {24'h0, g[i[2:0]][7:0]} : {24'h0, g[i[2:0]][15:8]}; // [RL19]
      SZ_WORD: rd_op = i[3] ? {16'h0, g[i[2:0]][31:16]} : {16'h0, g[i[2:0]][15:0]};
      default: rd_op = g[i[2:0]];
    endcase
  endfunction

  function automatic ctad_gpr_type wr_op(ctad_gpr_type g, logic [1:0] s, logic [3:0] i,
                                          logic [31:0] val);
    wr_op = g;
    case (s)
      SZ_BYTE: begin
        if (i[3]) begin
          wr_op[i[2:0]][7:0] = val[7:0]; // [RL19]
        end else begin
          wr_op[i[2:0]][15:8] = val[7:0];
        end
      end
      SZ_WORD: begin
        if (i[3]) begin
          wr_op[i[2:0]][31:16] = val[15:0];
        end else begin
          wr_op[i[2:0]][15:0] = val[15:0];
        end
      end
      default: wr_op[i[2:0]] = val;
    endcase
  endfunction

  function automatic logic [7:0] nzv(logic [7:0] fl, logic [1:0] s, logic [31:0] val,
                                     logic ov);
    logic [31:0] t;
    t = val << shift_of(s);
    nzv = fl;
    nzv[`CTAD_FLG_N] = t[31]; // [RL20]
    nzv[`CTAD_FLG_Z] = (t == 32'h0);
    nzv[`CTAD_FLG_V] = ov;
  endfunction

  function automatic logic bad_cmd(ctad_cmd_type c);
    case (c.op)
      OP_SUB: bad_cmd = (c.use_imm && c.size == SZ_BYTE) || c.size == 2'b11; // [RL6]
      OP_ADD_WITH_CARRY, OP_SUB_WITH_CARRY: bad_cmd = c.size != SZ_BYTE; // [RL7]
      OP_DECIMAL_ADJUST_ADD, OP_DECIMAL_ADJUST_SUB: bad_cmd = c.size != SZ_BYTE;
      OP_INC, OP_DEC: bad_cmd = (c.size == SZ_BYTE && c.step != 2'h0) || c.step[1]
                                || c.size == 2'b11; // [RL8]
      OP_ADDRESS_ADD_CONST, OP_ADDRESS_SUB_CONST: bad_cmd = c.size != SZ_LONG
                                                 || c.step == 2'h3; // [RL9]
      OP_UNSIGNED_MULTIPLY, OP_SIGNED_MULTIPLY: bad_cmd = c.size[1];
      OP_UNSIGNED_DIVIDE, OP_SIGNED_DIVIDE: bad_cmd = c.size[1];
      OP_POP, OP_PUSH, OP_ZERO_EXTEND, OP_SIGN_EXTEND: bad_cmd = c.size == SZ_BYTE
                                                     || c.size == 2'b11;
      default: bad_cmd = c.size == 2'b11;
    endcase
  endfunction

  function automatic logic mapped(logic [11:0] ad);
    mapped = ad == `CTAD_OFF_CMD || ad == `CTAD_OFF_IMM || ad == `CTAD_OFF_FLAGS
             || ad == `CTAD_OFF_STATUS || (ad & `CTAD_GPR_MASK) == `CTAD_OFF_GPR;
  endfunction

  always_comb begin
    n = r;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    sz = r.cmd.size;
    dsz = sz + 2'h1;
    sh = shift_of(sz);
    stepv = 32'h0000_0001 << r.cmd.step;
    bad = bad_cmd(r.cmd);
    a = rd_op(r.gpr, sz, r.cmd.rd);
    adst = rd_op(r.gpr, dsz, r.cmd.rd);
    b = (r.cmd.use_imm || r.cmd.op == OP_MOVE_IMM) ? size_mask(sz, r.imm)
        : rd_op(r.gpr, sz, r.cmd.rs);
    x = a;
    y = b;
    cin = 1'b0;
    sub = 1'b0;
    case (r.cmd.op)
      OP_ADD_WITH_CARRY: cin = r.flags[`CTAD_FLG_C]; // [RL7]
      OP_SUB_WITH_CARRY: begin
        cin = r.flags[`CTAD_FLG_C];
        sub = 1'b1;
      end
      OP_SUB, OP_COMPARE: sub = 1'b1;
      OP_INC: y = stepv; // [RL8]
      OP_DEC: begin
        y = stepv;
        sub = 1'b1;
      end
      OP_NEGATE: begin
        x = 32'h0; // [RL16]
        y = a;
        sub = 1'b1;
      end
      default: sub = 1'b0;
    endcase
    // Operands are aligned to bit 31 so carry and overflow share one adder; half carry uses a second sum over bits 27:0.
    xs = x << sh;
    ys = y << sh;
    cs = {31'h0, cin} << sh;
    if (sub) begin
      top = {1'b0, xs} - {1'b0, ys} - {1'b0, cs};
      half = {1'b0, xs[27:0]} - {1'b0, ys[27:0]} - {1'b0, cs[27:0]};
      v = (xs[31] != ys[31]) && (top[31] != xs[31]);
    end else begin
      top = {1'b0, xs} + {1'b0, ys} + {1'b0, cs};
      half = {1'b0, xs[27:0]} + {1'b0, ys[27:0]} + {1'b0, cs[27:0]};
      v = (xs[31] == ys[31]) && (top[31] != xs[31]);
    end
    sum = top[31:0] >> sh;
    f = nzv(r.flags, sz, sum, v);
    res = 32'h0;
    q = 32'h0;
    rm = 32'h0;
    spn = r.gpr[`CTAD_SP_IDX] - size_bytes(sz);
    dadj = 8'h00;
    if (r.st == ST_EXEC) begin
      n.st = ST_IDLE;
      if (bad) begin
        n.illegal = 1'b1;
      end else begin
        case (r.cmd.op)
          OP_MOVE_REG, OP_MOVE_IMM: begin
            n.gpr = wr_op(r.gpr, sz, r.cmd.rd, b); // [RL1]
            n.flags = nzv(r.flags, sz, b, 1'b0);
          end
          OP_MOVE_LOAD: begin
            n.mem = '{1'b1, 1'b0, sz, even_addr(sz, r.gpr[r.cmd.rs[2:0]]), 32'h0}; // [RL1]
            n.st = ST_MEM;
          end
          OP_MOVE_STORE: begin
            n.mem = '{1'b1, 1'b1, sz, even_addr(sz, r.gpr[r.cmd.rd[2:0]]), b}; // [RL1]
            n.flags = nzv(r.flags, sz, b, 1'b0);
            n.st = ST_MEM;
          end
          OP_POP: begin
            n.mem = '{1'b1, 1'b0, sz, even_addr(sz, r.gpr[`CTAD_SP_IDX]), 32'h0}; // [RL3]
            n.st = ST_MEM;
          end
          OP_PUSH: begin
            n.gpr[`CTAD_SP_IDX] = spn; // [RL4]
            n.mem = '{1'b1, 1'b1, sz, even_addr(sz, spn), b};
            n.flags = nzv(r.flags, sz, b, 1'b0);
            n.st = ST_MEM;
          end
          OP_ADD, OP_SUB, OP_ADD_WITH_CARRY, OP_SUB_WITH_CARRY, OP_INC, OP_DEC,
          OP_NEGATE, OP_COMPARE: begin
            if (r.cmd.op != OP_COMPARE) begin
              n.gpr = wr_op(r.gpr, sz, r.cmd.rd, sum); // [RL5] [RL15]
            end
            if (r.cmd.op != OP_INC && r.cmd.op != OP_DEC) begin
              f[`CTAD_FLG_C] = top[32]; // [RL21]
              f[`CTAD_FLG_H] = half[28];
            end
            if (r.cmd.op == OP_ADD_WITH_CARRY || r.cmd.op == OP_SUB_WITH_CARRY) begin
              f[`CTAD_FLG_Z] = f[`CTAD_FLG_Z] & r.flags[`CTAD_FLG_Z]; // [RL7]
            end
            n.flags = f; // [RL20]
          end
          OP_ADDRESS_ADD_CONST: n.gpr[r.cmd.rd[2:0]] = r.gpr[r.cmd.rd[2:0]] + stepv; // [RL9]
          OP_ADDRESS_SUB_CONST: n.gpr[r.cmd.rd[2:0]] = r.gpr[r.cmd.rd[2:0]] - stepv; // [RL9]
          OP_DECIMAL_ADJUST_ADD, OP_DECIMAL_ADJUST_SUB: begin
            f = nzv(r.flags, SZ_BYTE, a, 1'b0);
            if (r.cmd.op == OP_DECIMAL_ADJUST_ADD) begin
              if (r.flags[`CTAD_FLG_C] || a[7:0] > 8'h99) begin
                dadj[7:4] = 4'h6; // [RL10]
                f[`CTAD_FLG_C] = 1'b1;
              end
              if (r.flags[`CTAD_FLG_H] || a[3:0] > 4'h9) begin
                dadj[3:0] = 4'h6;
              end
              res = {24'h0, a[7:0] + dadj};
            end else begin
              if (r.flags[`CTAD_FLG_C]) begin
                dadj[7:4] = 4'h6; // [RL10]
              end
              if (r.flags[`CTAD_FLG_H]) begin
                dadj[3:0] = 4'h6;
              end
              res = {24'h0, a[7:0] - dadj};
            end
            n.gpr = wr_op(r.gpr, SZ_BYTE, r.cmd.rd, res);
            n.flags = nzv(f, SZ_BYTE, res, 1'b0);
          end
          OP_UNSIGNED_MULTIPLY, OP_SIGNED_MULTIPLY: begin
            if (r.cmd.op == OP_SIGNED_MULTIPLY) begin
              if (sz == SZ_BYTE) begin
                res = {16'h0, 16'($signed(adst[7:0]) * $signed(b[7:0]))}; // [RL12]
              end else begin
                res = 32'($signed(adst[15:0]) * $signed(b[15:0])); // [RL12]
              end
              n.flags = nzv(r.flags, dsz, res, 1'b0);
            end else if (sz == SZ_BYTE) begin
              res = {16'h0, 16'(adst[7:0] * b[7:0])}; // [RL11]
            end else begin
              res = 32'(adst[15:0] * b[15:0]); // [RL11]
            end
            n.gpr = wr_op(r.gpr, dsz, r.cmd.rd, res);
          end
          OP_UNSIGNED_DIVIDE, OP_SIGNED_DIVIDE: begin
            if (b == 32'h0) begin
              n.div0 = 1'b1; // [RL23]
            end else begin
              if (r.cmd.op == OP_SIGNED_DIVIDE && sz == SZ_BYTE) begin
                q = 32'($signed(adst[15:0]) / $signed({{8{b[7]}}, b[7:0]})); // [RL14]
                rm = 32'($signed(adst[15:0]) % $signed({{8{b[7]}}, b[7:0]}));
              end else if (r.cmd.op == OP_SIGNED_DIVIDE) begin
                q = 32'($signed(adst) / $signed({{16{b[15]}}, b[15:0]})); // [RL14]
                rm = 32'($signed(adst) % $signed({{16{b[15]}}, b[15:0]}));
              end else if (sz == SZ_BYTE) begin
                q = {16'h0, adst[15:0] / {8'h00, b[7:0]}}; // [RL13]
                rm = {16'h0, adst[15:0] % {8'h00, b[7:0]}};
              end else begin
                q = adst / {16'h0, b[15:0]}; // [RL13]
                rm = adst % {16'h0, b[15:0]};
              end
              res = (sz == SZ_BYTE) ? {16'h0, rm[7:0], q[7:0]} : {rm[15:0], q[15:0]};
              n.gpr = wr_op(r.gpr, dsz, r.cmd.rd, res);
              n.flags = nzv(r.flags, sz, q, 1'b0);
            end
          end
          OP_ZERO_EXTEND, OP_SIGN_EXTEND: begin
            if (sz == SZ_WORD) begin
              res = {24'h0, a[7:0]}; // [RL17]
              if (r.cmd.op == OP_SIGN_EXTEND) begin
                res[15:8] = {8{a[7]}}; // [RL18]
              end
            end else begin
              res = {16'h0, a[15:0]}; // [RL17]
              if (r.cmd.op == OP_SIGN_EXTEND) begin
                res[31:16] = {16{a[15]}}; // [RL18]
              end
            end
            n.gpr = wr_op(r.gpr, sz, r.cmd.rd, res);
            n.flags = nzv(r.flags, sz, res, 1'b0);
          end
          default: n.illegal = 1'b1; // [RL2]
        endcase
      end
    end else if (r.st == ST_MEM && mem_ack) begin
      n.mem.req = 1'b0;
      n.st = ST_IDLE;
      if (!r.mem.we) begin
        if (r.cmd.op == OP_POP) begin
          n.gpr[`CTAD_SP_IDX] = r.gpr[`CTAD_SP_IDX] + size_bytes(sz); // [RL3]
        end
        n.gpr = wr_op(n.gpr, sz, r.cmd.rd, size_mask(sz, mem_rdata)); // [RL1] [RL3]
        n.flags = nzv(r.flags, sz, size_mask(sz, mem_rdata), 1'b0);
      end
    end
    // Writes are only taken while idle, so they never meet a running operation.
    if (psel && penable && !r.pready) begin
      n.pready = 1'b1;
      n.pslverr = !mapped(paddr) || (pwrite && r.st != ST_IDLE);
      n.prdata = 32'h0;
      if (!pwrite) begin
        case (paddr)
          `CTAD_OFF_CMD: n.prdata = r.cmd;
          `CTAD_OFF_IMM: n.prdata = r.imm;
          `CTAD_OFF_FLAGS: n.prdata = {24'h0, r.flags};
          `CTAD_OFF_STATUS: n.prdata = {29'h0, r.div0, r.illegal, r.st != ST_IDLE};
          default: begin
            if (mapped(paddr)) begin
              n.prdata = r.gpr[paddr[4:2]];
            end
          end
        endcase
      end
    end
    if (psel && penable && r.pready && pwrite && !r.pslverr) begin
      case (paddr)
        `CTAD_OFF_CMD: begin
          n.cmd = ctad_cmd_type'(pwdata);
          n.st = ST_EXEC;
          n.illegal = 1'b0;
          n.div0 = 1'b0;
        end
        `CTAD_OFF_IMM: n.imm = pwdata;
        `CTAD_OFF_FLAGS: n.flags = pwdata[7:0];
        `CTAD_OFF_STATUS: n.imm = r.imm;
        default: n.gpr[paddr[4:2]] = pwdata;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign mem_out = r.mem;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_exec_op(ctad_op_type o);
    r.st == ST_EXEC && r.cmd.op == o && !bad;
  endsequence

  sequence s_push_issue;
    r.mem.req && r.mem.we && r.st == ST_MEM;
  endsequence

  a_periph_refused: assert property ( // [RL2]
    r.st == ST_EXEC && (r.cmd.op == OP_MOVE_FROM_PERIPH || r.cmd.op == OP_MOVE_TO_PERIPH)
    |=> r.illegal && !r.mem.req && r.gpr == $past(r.gpr))
    else $error("peripheral move not refused");
  a_pop_post_inc: assert property ( // [RL3]
    r.st == ST_MEM && r.cmd.op == OP_POP && mem_ack && r.cmd.rd[2:0] != `CTAD_SP_IDX
    |=> r.gpr[`CTAD_SP_IDX] == $past(r.gpr[`CTAD_SP_IDX]) + size_bytes($past(sz)))
    else $error("pop did not advance stack pointer");
  a_push_pre_dec: assert property ( // [RL4]
    s_exec_op(OP_PUSH) |=> s_push_issue ##0
    (r.gpr[`CTAD_SP_IDX] == $past(r.gpr[`CTAD_SP_IDX]) - size_bytes($past(sz))
     && r.mem.addr == {r.gpr[`CTAD_SP_IDX][31:1], 1'b0}))
    else $error("push address not the decremented stack pointer");
  a_add_result: assert property ( // [RL5]
    s_exec_op(OP_ADD) |=> rd_op(r.gpr, $past(sz), $past(r.cmd.rd))
    == size_mask($past(sz), $past(a) + $past(b)))
    else $error("add result wrong");
  a_sub_imm_byte: assert property ( // [RL6]
    r.st == ST_EXEC && r.cmd.op == OP_SUB && r.cmd.use_imm && r.cmd.size == SZ_BYTE
    |=> r.illegal && r.gpr == $past(r.gpr))
    else $error("byte immediate subtract not refused");
  a_inc_byte_two: assert property ( // [RL8]
    r.st == ST_EXEC && r.cmd.op == OP_INC && r.cmd.size == SZ_BYTE && r.cmd.step != 2'h0
    |=> r.illegal)
    else $error("byte increment by two not refused");
  a_address_const: assert property ( // [RL9]
    s_exec_op(OP_ADDRESS_ADD_CONST) |=> r.gpr[$past(r.cmd.rd[2:0])]
    == $past(r.gpr[r.cmd.rd[2:0]]) + $past(stepv))
    else $error("address add constant wrong");
  a_compare_no_write: assert property ( // [RL15]
    s_exec_op(OP_COMPARE) |=> r.gpr == $past(r.gpr) && r.st == ST_IDLE)
    else $error("compare changed a register");
  a_zero_flag: assert property ( // [RL20]
    s_exec_op(OP_ADD) |=> r.flags[`CTAD_FLG_Z]
    == (rd_op(r.gpr, $past(sz), $past(r.cmd.rd)) == 32'h0))
    else $error("zero flag does not match result");
  a_mem_even: assert property ( // [RL22]
    r.mem.req && r.mem.size != SZ_BYTE |-> !r.mem.addr[0])
    else $error("odd word address issued");
  a_div_zero: assert property ( // [RL23]
    (s_exec_op(OP_UNSIGNED_DIVIDE) or s_exec_op(OP_SIGNED_DIVIDE)) ##0 b == 32'h0
    |=> r.div0 && r.st == ST_IDLE && r.gpr == $past(r.gpr))
    else $error("zero divisor not handled");
endmodule
`default_nettype wire

// File: ctad_mem_model.sv
// Memory model that answers the datapath's load and store requests.
`default_nettype none
module ctad_mem_model
  import ctad_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire ctad_mem_type mem_in,
  input wire logic [1:0] delay,
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  output logic [31:0] last_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] store [logic [31:0]];
  logic [1:0] wait_cnt;
  // Read data toggles every cycle except when a read of a stored address is answered, so stale values are never trusted.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_cnt <= 2'h0;
      last_addr <= 32'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_in.req && !mem_ack) begin
        wait_cnt <= wait_cnt + 2'h1;
        if (wait_cnt >= delay) begin
          mem_ack <= 1'b1;
          wait_cnt <= 2'h0;
          last_addr <= mem_in.addr;
          if (mem_in.we) begin
            store[mem_in.addr] = mem_in.wdata;
          end else if (store.exists(mem_in.addr)) begin
            mem_rdata <= store[mem_in.addr];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: cpu_transfer_arith_datapath_tb.sv
// Self-checking bench of the datapath against an integer model.
`default_nettype none
`include "ctad_defs.svh"
module cpu_transfer_arith_datapath_tb import ctad_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_ack, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_rdata, last_addr, q, a, b, sp;
  logic [1:0] delay;
  ctad_mem_type mem_out;
  int error_cnt = 0, checks_done = 0, seed = 43703;
  logic [31:0] m_gpr [8];
  ctad_datapath i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_out(mem_out), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  ctad_mem_model i_mem (.pclk(pclk), .presetn(presetn), .mem_in(mem_out), .delay(delay),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .last_addr(last_addr));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task give_verdict;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] y);
    checks_done++;
    if (y !== x) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, x, y);
    end
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      error_cnt++;
      give_verdict;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task run(input logic [31:0] c);
    int n;
    n = 0;
    delay <= 2'($random(seed));
    apb(1'b1, `CTAD_OFF_CMD, c);
    do begin
      apb(1'b0, `CTAD_OFF_STATUS, 32'h0);
      n++;
    end while (q[`CTAD_ST_BUSY] !== 1'b0 && n < 40);
    if (n >= 40) begin
      error_cnt++;
      give_verdict;
    end
  endtask
  task sg(input int n, input logic [31:0] v);
    apb(1'b1, 12'(`CTAD_OFF_GPR + 4 * n), v);
    m_gpr[n] = v;
  endtask
  task gg(input int n);
    apb(1'b0, 12'(`CTAD_OFF_GPR + 4 * n), 32'h0);
    chk("gpr", m_gpr[n], q);
  endtask
  task gf(input logic [3:0] x);
    apb(1'b0, `CTAD_OFF_FLAGS, 32'h0);
    chk("flags", {28'h0, x}, {28'h0, q[3:0]});
  endtask
  function logic [31:0] cm(input ctad_op_type o, input ctad_size_type s, input logic i,
    input logic [3:0] d, input logic [3:0] r);
    return {16'h0, r, d, i, s, o};
  endfunction
  function logic [3:0] fl(input logic [31:0] x, input logic [31:0] y, input logic s);
    logic [32:0] t;
    t = s ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
    return {t[31], t[31:0] == 32'h0, x[31] == (y[31] ^ s) && t[31] != x[31], t[32]};
  endfunction
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    delay = 2'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    gf(4'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    for (int k = 0; k < 8; k++) begin
      m_gpr[k] = `CTAD_WORD_RST;
      gg(k);
    end
    for (int k = 0; k < 4; k++) begin
      a = $random(seed);
      b = (k == 1) ? -a : $random(seed);
      sg(1, a);
      sg(2, b);
      run(cm(OP_ADD, SZ_LONG, 1'b0, 4'h1, 4'h2));
      m_gpr[1] = a + b;
      gg(1);
      gf(fl(a, b, 1'b0));
      run(cm(OP_COMPARE, SZ_LONG, 1'b0, 4'h1, 4'h2));
      gg(1);
      gf(fl(a + b, b, 1'b1));
    end
    run(cm(OP_NEGATE, SZ_LONG, 1'b0, 4'h2, 4'h0));
    m_gpr[2] = 32'h0 - m_gpr[2];
    gg(2);
    apb(1'b1, `CTAD_OFF_IMM, a);
    run(cm(OP_SUB, SZ_BYTE, 1'b1, 4'h8, 4'h0));
    chk("illegal", 32'h1, {31'h0, q[`CTAD_ST_ILLEGAL]});
    gg(0);
    run(cm(OP_MOVE_IMM, SZ_LONG, 1'b1, 4'h0, 4'h0));
    m_gpr[0] = a;
    gg(0);
    sg(3, a);
    sg(4, b | 32'h8000);
    run(cm(OP_UNSIGNED_MULTIPLY, SZ_BYTE, 1'b0, 4'h3, 4'hc));
    m_gpr[3][15:0] = {8'h0, a[7:0]} * {8'h0, b[7:0]};
    gg(3);
    sg(5, a & 32'h7fff_ffff);
    run(cm(OP_UNSIGNED_DIVIDE, SZ_WORD, 1'b0, 4'h5, 4'h4));
    sp = m_gpr[5];
    m_gpr[5] = {16'(sp % m_gpr[4][15:0]), 16'(sp / m_gpr[4][15:0])};
    gg(5);
    sg(4, 32'hffff_0000);
    run(cm(OP_UNSIGNED_DIVIDE, SZ_WORD, 1'b0, 4'h5, 4'h4));
    chk("div0", 32'h1, {31'h0, q[`CTAD_ST_DIV0]});
    gg(5);
    sg(6, b);
    run(cm(OP_SIGN_EXTEND, SZ_WORD, 1'b0, 4'h6, 4'h0));
    m_gpr[6][15:8] = {8{b[7]}};
    gg(6);
    sp = {20'h0, a[11:0]} | 32'h101;
    sg(7, sp);
    run(cm(OP_PUSH, SZ_LONG, 1'b0, 4'h0, 4'h1));
    chk("push addr", (sp - 32'h4) & ~32'h1, last_addr);
    m_gpr[7] = sp - 32'h4;
    gg(7);
    run(cm(OP_POP, SZ_LONG, 1'b0, 4'h2, 4'h0));
    m_gpr[2] = m_gpr[1];
    m_gpr[7] = sp;
    gg(2);
    gg(7);
    apb(1'b1, `CTAD_OFF_FLAGS, 32'h1);
    run(cm(OP_ADD_WITH_CARRY, SZ_BYTE, 1'b0, 4'h8, 4'h9));
    m_gpr[0][7:0] = m_gpr[0][7:0] + m_gpr[1][7:0] + 8'h1;
    gg(0);
    run(cm(OP_ADDRESS_ADD_CONST, SZ_LONG, 1'b0, 4'h6, 4'h0) | 32'h0002_0000);
    m_gpr[6] = m_gpr[6] + 32'h4;
    gg(6);
    run(cm(OP_INC, SZ_WORD, 1'b0, 4'h6, 4'h0) | 32'h0001_0000);
    m_gpr[6][15:0] = m_gpr[6][15:0] + 16'h2;
    gg(6);
    run(cm(OP_INC, SZ_BYTE, 1'b0, 4'h6, 4'h0) | 32'h0001_0000);
    chk("illegal", 32'h1, {31'h0, q[`CTAD_ST_ILLEGAL]});
    run(cm(OP_MOVE_FROM_PERIPH, SZ_BYTE, 1'b0, 4'h6, 4'h0));
    chk("illegal", 32'h1, {31'h0, q[`CTAD_ST_ILLEGAL]});
    gg(6);
    run(cm(OP_ZERO_EXTEND, SZ_LONG, 1'b0, 4'h5, 4'h0));
    m_gpr[5][31:16] = 16'h0;
    gg(5);
    sg(3, a);
    run(cm(OP_SIGNED_MULTIPLY, SZ_WORD, 1'b0, 4'h3, 4'hc));
    m_gpr[3] = 32'h0 - {{16{a[15]}}, a[15:0]};
    gg(3);
    give_verdict;
  end
endmodule
`default_nettype wire
